// File: include/owdec_pkg.sv
// Constants, register map and state encoding of the one-wire bus decoder
package owdec_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TB_STD_NS = 1000;
  localparam int TB_HI_NS = 200;
  localparam logic [6:0] TB_STD_CYC = 7'(TB_STD_NS / CLK_PERIOD_NS);
  localparam logic [6:0] TB_HI_CYC = 7'(TB_HI_NS / CLK_PERIOD_NS);
  localparam int RST_LOW_STD_NS = 480000;
  localparam int RST_LOW_HI_NS = 48000;
  localparam logic [8:0] RST_STD_U = 9'(RST_LOW_STD_NS / TB_STD_NS);
  localparam logic [8:0] RST_HI_U = 9'(RST_LOW_HI_NS / TB_HI_NS);
  localparam int PRES_WAIT_MAX_STD_NS = 60000;
  localparam int PRES_WAIT_MAX_HI_NS = 6000;
  localparam logic [8:0] PDH_STD_U = 9'(PRES_WAIT_MAX_STD_NS / TB_STD_NS);
  localparam logic [8:0] PDH_HI_U = 9'(PRES_WAIT_MAX_HI_NS / TB_HI_NS);
  localparam int PRES_LOW_MIN_STD_NS = 60000;
  localparam int PRES_LOW_MAX_STD_NS = 240000;
  localparam int PRES_LOW_MIN_HI_NS = 8000;
  localparam int PRES_LOW_MAX_HI_NS = 24000;
  localparam logic [8:0] PDL_MIN_STD_U = 9'((PRES_LOW_MIN_STD_NS + TB_STD_NS - 1) / TB_STD_NS);
  localparam logic [8:0] PDL_MAX_STD_U = 9'(PRES_LOW_MAX_STD_NS / TB_STD_NS);
  localparam logic [8:0] PDL_MIN_HI_U = 9'((PRES_LOW_MIN_HI_NS + TB_HI_NS - 1) / TB_HI_NS);
  localparam logic [8:0] PDL_MAX_HI_U = 9'(PRES_LOW_MAX_HI_NS / TB_HI_NS);
  localparam int SLOT_MIN_NS = 60000;
  localparam logic [8:0] SLOT_MIN_STD_U = 9'((SLOT_MIN_NS + TB_STD_NS - 1) / TB_STD_NS);
  localparam logic [8:0] SLOT_MIN_HI_U = 9'((SLOT_MIN_NS / 10 + TB_HI_NS - 1) / TB_HI_NS);
  localparam int WORD_W = 32;
  localparam int FIFO_DEPTH = 32;
  localparam logic [5:0] LEN_MIN = 6'h01;
  localparam logic [5:0] LEN_MAX = 6'h20;
  localparam logic [5:0] LEN_DEF = 6'h08;
  localparam logic [6:0] POS_MIN = 7'h01;
  localparam logic [6:0] POS_MAX = 7'h78;
  localparam logic [6:0] POS_DEF = 7'h1e;
  localparam logic [3:0] CHAN_DEF = 4'h0;
  localparam logic [6:0] ID_SKIP = 7'h08;
  localparam logic [6:0] ID_END = 7'h48;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CFG = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_RSTCNT = 8'h0c;
  localparam logic [7:0] ADDR_ID_LO = 8'h10;
  localparam logic [7:0] ADDR_ID_HI = 8'h14;
  localparam logic [7:0] ADDR_ID_INFO = 8'h18;
  localparam logic [7:0] ADDR_WORDS = 8'h1c;
  localparam int CTRL_EN = 0;
  localparam int CTRL_SPEED = 1;
  localparam int CTRL_MSB = 2;
  localparam int CTRL_CHAN = 4;
  localparam int CFG_LEN = 0;
  localparam int CFG_POS = 8;
  localparam int ST_PRES = 3;
  localparam int ST_OVR = 4;
  localparam int ST_FULL = 5;
  localparam int ST_IDV = 6;
  localparam int ST_SLOTE = 7;
  localparam int ST_RECE = 8;
  localparam int ST_PRESE = 9;
  localparam int ST_CNT = 16;
  typedef enum logic [2:0] {
    OWDEC_IDLE, OWDEC_RST, OWDEC_PDH, OWDEC_PDL, OWDEC_SLOT_IDLE, OWDEC_SLOT
  } owdec_state_t;
endpackage

// File: include/owdec_stream_if.sv
// Valid/ready word stream between decoder and FIFO
`timescale 1ns/1ps
`default_nettype none
interface owdec_stream_if #(parameter int W = 32);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// File: core/owdec_fifo.sv
// Word FIFO with a registered output stage
`timescale 1ns/1ps
`default_nettype none
module owdec_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 32
) (
  input wire logic core_clk, // Clock
  input wire logic sys_rst, // Async reset, high
  owdec_stream_if.snk in_s, // Filling side
  owdec_stream_if.src out_s // Draining side
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic ov;
    logic [W-1:0] od;
  } owdec_fifo_st_t;
  owdec_fifo_st_t q, d;
  logic push, pop;

  assign in_s.ready = (q.cnt != (AW+1)'(DEPTH));
  assign out_s.valid = q.ov;
  assign out_s.data = q.od;

  always_comb begin
    d = q;
    push = in_s.valid && (q.cnt != (AW+1)'(DEPTH));
    pop = (q.cnt != '0) && (!q.ov || out_s.ready);
    if (out_s.ready) begin
      d.ov = 1'b0;
    end
    if (pop) begin
      d.od = q.mem[q.rp];
      d.ov = 1'b1;
      d.rp = AW'(q.rp + 1'b1);
    end
    if (push) begin
      d.mem[q.wp] = in_s.data;
      d.wp = AW'(q.wp + 1'b1);
    end
    d.cnt = (AW+1)'(q.cnt + (AW+1)'(push) - (AW+1)'(pop));
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule // owdec_fifo
`default_nettype wire

// File: core/owdec_top.sv
// Passive one-wire bus decoder with register port and word FIFO
//
// Operation
// - Watch one selectable input channel as the data line, channel 0 by default.
// - Standard speed 1 us time base or high 0.2 us; standard after reset.
// - Place bits into the word MSB first or LSB first per setting.
// - Group 1 to 32 bits into one word, 8 by default.
// - Sample 1 to 120 time units after the slot falling edge, 30 default.
// - Low at the sampling point is a 0 bit, high is a 1 bit.
// - A detected reset starts a new communication period.
// - Identity code read LSB first: family byte, 48-bit serial, CRC byte.
`timescale 1ns/1ps
`default_nettype none
module owdec_top #(
  parameter int CHANNELS = 16,
  parameter int FIFO_W = owdec_pkg::WORD_W,
  parameter int FIFO_D = owdec_pkg::FIFO_DEPTH
) (
  input wire logic core_clk, // 100 MHz clock
  input wire logic sys_rst, // Async reset, high
  input wire logic [CHANNELS-1:0] chan_in, // Analyser input channels
  input wire logic [7:0] reg_addr, // Register byte address
  input wire logic [31:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [31:0] reg_rdata, // Read data, cycle after strobe
  output logic [FIFO_W-1:0] word_data, // Decoded word
  output logic word_valid, // Word available
  input wire logic word_ready, // Word taken
  output logic bit_strobe, // One-cycle pulse per sampled bit
  output logic bit_value, // Last sampled bit
  output logic reset_strobe, // One-cycle pulse per bus reset while enabled; with en clear it pulses every cycle of a long low
  output logic presence // Presence seen since last reset
);
  typedef struct packed {
    owdec_pkg::owdec_state_t st;
    logic en;
    logic speed_hi;
    logic msb_first;
    logic [3:0] chan;
    logic [5:0] len;
    logic [6:0] pos;
    logic line;
    logic [6:0] pre;
    logic [8:0] fall_u;
    logic [8:0] rise_u;
    logic sampled;
    logic [31:0] word;
    logic [5:0] cnt;
    logic pend;
    logic [31:0] pdata;
    logic overrun;
    logic presence;
    logic slot_err;
    logic rec_err;
    logic pres_err;
    logic [15:0] rst_cnt;
    logic [31:0] words;
    logic [6:0] id_cnt;
    logic [63:0] id_sh;
    logic [63:0] id;
    logic id_valid;
    logic [31:0] rdata;
    logic bit_stb;
    logic bit_val;
    logic rst_stb;
  } owdec_top_st_t;

  owdec_top_st_t q, d;
  logic cur, fall, rise, tick, take, bitv;
  logic [6:0] tb;
  logic [8:0] rst_u, pdh_u, pdl_min, pdl_max, slot_min;
  logic [5:0] idx, lenw;
  logic [6:0] posw;
  logic [31:0] r;

  owdec_stream_if #(.W(FIFO_W)) in_if ();
  owdec_stream_if #(.W(FIFO_W)) out_if ();

  owdec_fifo #(.W(FIFO_W), .DEPTH(FIFO_D)) u_fifo (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .in_s(in_if.snk),
    .out_s(out_if.src)
  );

  assign in_if.valid = q.pend;
  assign in_if.data = FIFO_W'(q.pdata);
  assign out_if.ready = word_ready;
  assign word_data = out_if.data;
  assign word_valid = out_if.valid;
  assign reg_rdata = q.rdata;
  assign bit_strobe = q.bit_stb;
  assign bit_value = q.bit_val;
  assign reset_strobe = q.rst_stb;
  assign presence = q.presence;

  always_comb begin
    d = q;
    d.rdata = '0;
    d.bit_stb = 1'b0;
    d.rst_stb = 1'b0;
    take = 1'b0;
    bitv = 1'b0;
    idx = '0;
    lenw = '0;
    posw = '0;
    r = '0;
    // Out-of-range channel reads as an idle, pulled-up line
    cur = (int'(q.chan) < CHANNELS) ? chan_in[q.chan] : 1'b1;
    d.line = cur;
    fall = q.line && !cur;
    rise = !q.line && cur;
    tb = q.speed_hi ? owdec_pkg::TB_HI_CYC : owdec_pkg::TB_STD_CYC;
    rst_u = q.speed_hi ? owdec_pkg::RST_HI_U : owdec_pkg::RST_STD_U;
    pdh_u = q.speed_hi ? owdec_pkg::PDH_HI_U : owdec_pkg::PDH_STD_U;
    pdl_min = q.speed_hi ? owdec_pkg::PDL_MIN_HI_U : owdec_pkg::PDL_MIN_STD_U;
    pdl_max = q.speed_hi ? owdec_pkg::PDL_MAX_HI_U : owdec_pkg::PDL_MAX_STD_U;
    slot_min = q.speed_hi ? owdec_pkg::SLOT_MIN_HI_U : owdec_pkg::SLOT_MIN_STD_U;
    tick = (q.pre == 7'(tb - 7'h01));

    // Prescaler realigns on each edge so unit counts start at the edge
    if (fall || rise || tick) begin
      d.pre = '0;
    end else begin
      d.pre = 7'(q.pre + 7'h01);
    end
    if (fall) begin
      d.fall_u = '0;
    end else if (tick && q.fall_u != '1) begin
      d.fall_u = 9'(q.fall_u + 9'h001);
    end
    if (rise) begin
      d.rise_u = '0;
    end else if (tick && q.rise_u != '1) begin
      d.rise_u = 9'(q.rise_u + 9'h001);
    end

    // Register writes come first so hardware events below win over clears
    if (reg_wr) begin
      case (reg_addr)
        owdec_pkg::ADDR_CTRL: begin
          d.en = reg_wdata[owdec_pkg::CTRL_EN];
          d.speed_hi = reg_wdata[owdec_pkg::CTRL_SPEED];
          d.msb_first = reg_wdata[owdec_pkg::CTRL_MSB];
          d.chan = reg_wdata[owdec_pkg::CTRL_CHAN +: 4];
        end
        owdec_pkg::ADDR_CFG: begin
          lenw = reg_wdata[owdec_pkg::CFG_LEN +: 6];
          posw = reg_wdata[owdec_pkg::CFG_POS +: 7];
          if (lenw < owdec_pkg::LEN_MIN) begin
            d.len = owdec_pkg::LEN_MIN;
          end else if (lenw > owdec_pkg::LEN_MAX) begin
            d.len = owdec_pkg::LEN_MAX;
          end else begin
            d.len = lenw;
          end
          if (posw < owdec_pkg::POS_MIN) begin
            d.pos = owdec_pkg::POS_MIN;
          end else if (posw > owdec_pkg::POS_MAX) begin
            d.pos = owdec_pkg::POS_MAX;
          end else begin
            d.pos = posw;
          end
        end
        owdec_pkg::ADDR_STATUS: begin
          if (reg_wdata[owdec_pkg::ST_OVR]) begin
            d.overrun = 1'b0;
          end
          if (reg_wdata[owdec_pkg::ST_SLOTE]) begin
            d.slot_err = 1'b0;
          end
          if (reg_wdata[owdec_pkg::ST_RECE]) begin
            d.rec_err = 1'b0;
          end
          if (reg_wdata[owdec_pkg::ST_PRESE]) begin
            d.pres_err = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    if (q.pend && in_if.ready) begin
      d.pend = 1'b0;
    end

    case (q.st)
      owdec_pkg::OWDEC_IDLE: begin
      end
      owdec_pkg::OWDEC_RST: begin
        if (rise) begin
          d.st = owdec_pkg::OWDEC_PDH;
        end
      end
      owdec_pkg::OWDEC_PDH: begin
        if (fall) begin
          d.st = owdec_pkg::OWDEC_PDL;
        end else if (q.rise_u > pdh_u) begin
          // No presence: slots are not decoded until the next reset
          d.st = owdec_pkg::OWDEC_IDLE;
        end
      end
      owdec_pkg::OWDEC_PDL: begin
        if (rise) begin
          d.presence = 1'b1;
          if (q.fall_u < pdl_min || q.fall_u > pdl_max) begin
            d.pres_err = 1'b1;
          end
          d.st = owdec_pkg::OWDEC_SLOT_IDLE;
        end
      end
      owdec_pkg::OWDEC_SLOT_IDLE: begin
        if (fall) begin
          d.st = owdec_pkg::OWDEC_SLOT;
          d.sampled = 1'b0;
        end
      end
      owdec_pkg::OWDEC_SLOT: begin
        if (fall) begin
          // Next slot opened: check the one that just ended
          if (q.sampled && q.fall_u < slot_min) begin
            d.slot_err = 1'b1;
          end
          if (q.sampled && q.rise_u == '0) begin
            d.rec_err = 1'b1;
          end
          d.sampled = 1'b0;
        end else if (!q.sampled && q.fall_u == 9'(q.pos)) begin
          take = 1'b1;
          bitv = cur;
          d.sampled = 1'b1;
        end
      end
      default: begin
        d.st = owdec_pkg::OWDEC_IDLE;
      end
    endcase

    if (take) begin
      d.bit_stb = 1'b1;
      d.bit_val = bitv;
      idx = q.msb_first ? 6'(q.len - 6'h01 - q.cnt) : q.cnt;
      d.word[idx[4:0]] = bitv;
      if (6'(q.cnt + 6'h01) >= q.len) begin
        if (d.pend) begin
          // Destination full: word is lost and flagged
          d.overrun = 1'b1;
        end else begin
          d.pend = 1'b1;
          d.pdata = d.word;
          d.words = 32'(q.words + 32'h00000001);
        end
        d.word = '0;
        d.cnt = '0;
      end else begin
        d.cnt = 6'(q.cnt + 6'h01);
      end
      // Identity code shifts in LSB first after the command byte
      if (q.id_cnt < owdec_pkg::ID_END) begin
        d.id_cnt = 7'(q.id_cnt + 7'h01);
        if (q.id_cnt >= owdec_pkg::ID_SKIP) begin
          d.id_sh = {bitv, q.id_sh[63:1]};
        end
        if (q.id_cnt == 7'(owdec_pkg::ID_END - 7'h01)) begin
          d.id = {bitv, q.id_sh[63:1]};
          d.id_valid = 1'b1;
        end
      end
    end

    // Reset detection overrides whatever the slot logic did
    if (q.st != owdec_pkg::OWDEC_RST && !q.line && !cur && q.fall_u >= rst_u) begin
      d.st = owdec_pkg::OWDEC_RST;
      d.word = '0;
      d.cnt = '0;
      d.presence = 1'b0;
      d.id_cnt = '0;
      d.rst_cnt = 16'(q.rst_cnt + 16'h0001);
      d.rst_stb = 1'b1;
    end
    if (!q.en) begin
      d.st = owdec_pkg::OWDEC_IDLE;
    end

    if (reg_rd) begin
      case (reg_addr)
        owdec_pkg::ADDR_CTRL: begin
          r[owdec_pkg::CTRL_EN] = q.en;
          r[owdec_pkg::CTRL_SPEED] = q.speed_hi;
          r[owdec_pkg::CTRL_MSB] = q.msb_first;
          r[owdec_pkg::CTRL_CHAN +: 4] = q.chan;
        end
        owdec_pkg::ADDR_CFG: begin
          r[owdec_pkg::CFG_LEN +: 6] = q.len;
          r[owdec_pkg::CFG_POS +: 7] = q.pos;
        end
        owdec_pkg::ADDR_STATUS: begin
          r[2:0] = q.st;
          r[owdec_pkg::ST_PRES] = q.presence;
          r[owdec_pkg::ST_OVR] = q.overrun;
          r[owdec_pkg::ST_FULL] = !in_if.ready;
          r[owdec_pkg::ST_IDV] = q.id_valid;
          r[owdec_pkg::ST_SLOTE] = q.slot_err;
          r[owdec_pkg::ST_RECE] = q.rec_err;
          r[owdec_pkg::ST_PRESE] = q.pres_err;
          r[owdec_pkg::ST_CNT +: 6] = q.cnt;
        end
        owdec_pkg::ADDR_RSTCNT: begin
          r[15:0] = q.rst_cnt;
        end
        owdec_pkg::ADDR_ID_LO: begin
          r = q.id[31:0];
        end
        owdec_pkg::ADDR_ID_HI: begin
          r = q.id[63:32];
        end
        owdec_pkg::ADDR_ID_INFO: begin
          r[7:0] = q.id[7:0];
          r[15:8] = q.id[63:56];
        end
        owdec_pkg::ADDR_WORDS: begin
          r = q.words;
        end
        default: begin
          r = '0;
        end
      endcase
      d.rdata = r;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
      q.st <= owdec_pkg::OWDEC_IDLE;
      q.en <= 1'b1;
      q.chan <= owdec_pkg::CHAN_DEF;
      q.speed_hi <= 1'b0;
      q.len <= owdec_pkg::LEN_DEF;
      q.pos <= owdec_pkg::POS_DEF;
      q.line <= 1'b1;
      q.fall_u <= '1;
      q.rise_u <= '1;
      q.sampled <= 1'b1;
    end else begin
      q <= d;
    end
  end
endmodule // owdec_top
`default_nettype wire

// File: tb/owdec_monitor.sv
// Port checker of the one-wire bus decoder, bound into its top module
`timescale 1ns/1ps
`default_nettype none
module owdec_monitor #(
  parameter int CHANNELS = 16,
  parameter int FIFO_W = 32
) (
  input wire logic core_clk, // Clock
  input wire logic sys_rst, // Async reset
  input wire logic [CHANNELS-1:0] chan_in, // Channels
  input wire logic [7:0] reg_addr, // Address
  input wire logic [31:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic [31:0] reg_rdata, // Read data
  input wire logic [FIFO_W-1:0] word_data, // Word
  input wire logic word_valid, // Word valid
  input wire logic word_ready, // Word taken
  input wire logic bit_strobe, // Bit pulse
  input wire logic bit_value, // Bit
  input wire logic reset_strobe, // Bus reset pulse
  input wire logic presence // Presence seen
);
  logic line;
  logic line_reg;
  logic [13:0] low_cnt_reg;
  logic [14:0] fall_cnt_reg;
  // Unused channels idle high, so the AND is the watched line
  assign line = &chan_in;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      line_reg <= 1'b1;
      low_cnt_reg <= 14'h0;
      fall_cnt_reg <= 15'h0;
    end else begin
      line_reg <= line;
      low_cnt_reg <= line ? 14'h0 : low_cnt_reg + 14'(low_cnt_reg != 14'h3fff);
      fall_cnt_reg <= (line_reg && !line) ? 15'h0 : fall_cnt_reg + 15'(fall_cnt_reg != 15'h7fff);
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  long_low_a: assert property (reset_strobe |-> low_cnt_reg >= 14'h12c0)
    else $error("bus reset flagged without a long low");
  rst_pulse_a: assert property (reset_strobe |=> !reset_strobe)
    else $error("bus reset pulse longer than one cycle");
  pres_clear_a: assert property (reset_strobe |-> ##[0:1] !presence)
    else $error("presence kept over a bus reset");
  bit_pulse_a: assert property (bit_strobe |=> !bit_strobe)
    else $error("bit pulse longer than one cycle");
  bit_level_a: assert property (bit_strobe |-> bit_value == $past(line))
    else $error("sampled bit differs from line level");
  bit_hold_a: assert property (!bit_strobe |-> $stable(bit_value))
    else $error("bit value changed without a sample");
  sample_delay_a: assert property (bit_strobe |-> fall_cnt_reg inside {[15'h12:15'h2f44]})
    else $error("sample outside the allowed delay after a fall");
  word_hold_a: assert property (word_valid && !word_ready |=> word_valid && $stable(word_data))
    else $error("word dropped or changed while stalled");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside the answer cycle");
endmodule // owdec_monitor
bind owdec_top owdec_monitor #(.CHANNELS(CHANNELS), .FIFO_W(FIFO_W)) mon (
  .core_clk, .sys_rst, .chan_in, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .word_data, .word_valid, .word_ready, .bit_strobe, .bit_value, .reset_strobe, .presence);
`default_nettype wire

// File: tb/owdec_line_model.sv
// Bus master and one slave driving the shared one-wire line
`timescale 1ns/1ps
`default_nettype none
module owdec_line_model (
  input wire logic core_clk, // Clock
  input wire logic hi, // High speed timing
  output logic line // Line with pull-up
);
  logic master_low = 1'b0;
  logic slave_low = 1'b0;
  // Open drain: a released line goes to the pull-up level
  assign line = !(master_low || slave_low);
  task automatic hold(input int n);
    repeat (n * (hi ? 20 : 100)) @(posedge core_clk);
  endtask
  task automatic bus_reset();
    @(posedge core_clk);
    master_low <= 1'b1;
    hold(hi ? 250 : 490);
    master_low <= 1'b0;
    hold(hi ? 15 : 30);
    slave_low <= 1'b1;
    hold(hi ? 60 : 120);
    slave_low <= 1'b0;
    hold(20);
  endtask
  // In a read slot the slave keeps the line low for a 0
  task automatic slot(input logic b, input logic rd);
    @(posedge core_clk);
    master_low <= 1'b1;
    hold(5);
    master_low <= !b && !rd;
    slave_low <= !b && rd;
    hold(25);
    master_low <= 1'b0;
    slave_low <= 1'b0;
    hold(5);
  endtask
endmodule // owdec_line_model
`default_nettype wire

// File: tb/owdec_top_test.sv
// Self-checking bench of the one-wire bus decoder
`timescale 1ns/1ps
`default_nettype none
module owdec_top_test;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic hi = 1'b0;
  logic line;
  logic [3:0] route = 4'h0;
  logic [15:0] chan_in;
  logic [7:0] reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic word_ready = 1'b1;
  logic [31:0] reg_rdata, word_data, d;
  logic word_valid, bit_strobe, bit_value, reset_strobe, presence;
  logic [31:0] wq[$];
  logic [31:0] cfg_w[4] = '{32'h0, 32'h7f3f, 32'h0a01, 32'h0a08};
  logic [31:0] cfg_e[4] = '{32'h0101, 32'h7820, 32'h0a01, 32'h0a08};
  int err_total = 0;
  int checked = 0;
  int nbits = 0;
  int nrst = 0;
  int i;
  always #5 core_clk = !core_clk;
  // Line on one channel, all others idle high
  assign chan_in = ~(16'(!line) << route);
  owdec_line_model bus (.core_clk(core_clk), .hi(hi), .line(line));
  owdec_top uut (.core_clk(core_clk), .sys_rst(sys_rst), .chan_in(chan_in), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .word_data(word_data), .word_valid(word_valid), .word_ready(word_ready), .bit_strobe(bit_strobe),
    .bit_value(bit_value), .reset_strobe(reset_strobe), .presence(presence));
  always @(posedge core_clk) begin
    if (word_valid && word_ready) wq.push_back(word_data);
    if (bit_strobe) nbits++;
    if (reset_strobe) nrst++;
  end
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic end_sim();
    $display("compares %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Odd bits go out as read slots
  task automatic send(input logic [31:0] v, input int n);
    for (int k = 0; k < n; k++) bus.slot(v[k], k[0]);
  endtask
  task automatic wait_words(input int n);
    for (int k = 0; k < 3000 && wq.size() < n; k++) @(posedge core_clk);
    if (wq.size() < n) begin
      err_total++;
      $display("BAD word count expected %0d seen %0d", n, wq.size());
      end_sim();
    end
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(owdec_pkg::ADDR_CTRL);
    chk("ctrl reset", d, 32'h1);
    rd(owdec_pkg::ADDR_CFG);
    chk("cfg reset", d, 32'h1e08);
    rd(8'h40);
    chk("unmapped", d, 32'h0);
    // Last row leaves 8 bits and an early sample point
    foreach (cfg_w[j]) begin
      wr(owdec_pkg::ADDR_CFG, cfg_w[j]);
      rd(owdec_pkg::ADDR_CFG);
      chk("cfg limits", d, cfg_e[j]);
    end
    hi <= 1'b1;
    route <= 4'h5;
    wr(owdec_pkg::ADDR_CTRL, 32'h3);
    bus.bus_reset();
    chk("wrong channel", 32'(nrst), 32'h0);
    // High-speed reset length is far too short at standard speed
    wr(owdec_pkg::ADDR_CTRL, 32'h51);
    bus.bus_reset();
    chk("short low at std", 32'(nrst), 32'h0);
    wr(owdec_pkg::ADDR_CTRL, 32'h53);
    bus.bus_reset();
    chk("reset seen", 32'(nrst), 32'h1);
    chk("presence", 32'(presence), 32'h1);
    send(32'h35, 8);
    wait_words(1);
    chk("lsb word", wq[0], 32'h35);
    chk("bit count", 32'(nbits), 32'h8);
    wr(owdec_pkg::ADDR_CTRL, 32'h57);
    send(32'h35, 8);
    wait_words(2);
    chk("msb word", wq[1], 32'hac);
    send(32'h7, 3);
    rd(owdec_pkg::ADDR_STATUS);
    chk("partial bits", 32'(d[21:16]), 32'h3);
    bus.bus_reset();
    send(32'h0f, 8);
    wait_words(3);
    chk("word after reset", wq[2], 32'hf0);
    rd(owdec_pkg::ADDR_RSTCNT);
    chk("reset count", d, 32'h2);
    wr(owdec_pkg::ADDR_CTRL, 32'h53);
    wr(owdec_pkg::ADDR_CFG, 32'h0a01);
    word_ready <= 1'b0;
    send(32'h55555555, 32);
    send(32'h5, 3);
    rd(owdec_pkg::ADDR_STATUS);
    chk("fifo full", 32'(d[owdec_pkg::ST_FULL]), 32'h1);
    chk("overrun", 32'(d[owdec_pkg::ST_OVR]), 32'h1);
    wr(owdec_pkg::ADDR_STATUS, 32'h10);
    rd(owdec_pkg::ADDR_STATUS);
    chk("overrun cleared", 32'(d[owdec_pkg::ST_OVR]), 32'h0);
    chk("timing errors", 32'(d[9:7]), 32'h0);
    word_ready <= 1'b1;
    wait_words(37);
    repeat (50) @(posedge core_clk);
    chk("drained", 32'(wq.size()), 32'h25);
    for (i = 0; i < 34; i++) chk("drained word", wq[i + 3], 32'(!i[0]));
    // 43 bits since the last reset; 29 more complete the identity code
    send(32'h01234567, 29);
    rd(owdec_pkg::ADDR_ID_LO);
    chk("id low", d, 32'h55555555);
    rd(owdec_pkg::ADDR_ID_HI);
    chk("id high", d, 32'h091a2b3d);
    rd(owdec_pkg::ADDR_ID_INFO);
    chk("id fields", d, 32'h00000955);
    rd(owdec_pkg::ADDR_STATUS);
    chk("id valid", 32'(d[owdec_pkg::ST_IDV]), 32'h1);
    rd(owdec_pkg::ADDR_WORDS);
    chk("word total", d, 32'h42);
    end_sim();
  end
endmodule // owdec_top_test
`default_nettype wire
